// >>> hdl/asq_pkg.sv
// package of constants and types for the sequence, queue and halt control block
package asq_pkg;

   // register bus geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL       = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_CMPL_LO    = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_CMPL_HI    = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STS    = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_START      = 3'h6;
   localparam logic [ADDR_W-1:0] OFS_OTHER_CTRL = 3'h7;

   // sequence_queue_freeze_control fields
   localparam int HALT_LSB  = 0;
   localparam int HALT_MSB  = 1;
   localparam int QUEUE_BIT = 2;
   localparam int LEN_LSB   = 3;
   localparam int LEN_MSB   = 6;
   localparam int RSVD_BIT  = 7;
   localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'h7f;
   localparam logic [DATA_W-1:0] CTRL_RESET   = 8'h20;

   // sequence_start_register fields
   localparam int START_SCAN_BIT = 0;

   // converter_status_zero fields
   localparam int STS_POS_LSB    = 0;
   localparam int STS_POS_MSB    = 3;
   localparam int STS_FROZEN_BIT = 5;
   localparam int STS_BUSY_BIT   = 6;
   localparam int STS_SEQ_BIT    = 7;

   // interrupt status and mask fields
   localparam int IRQ_SEQ_BIT   = 0;
   localparam int IRQ_ABORT_BIT = 1;
   localparam int IRQ_W         = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

   // result file
   localparam int POS_W       = 4;
   localparam int NUM_RESULTS = 16;

   typedef enum logic [1:0] {
      HALT_RUN    = 2'b00,
      HALT_RSVD   = 2'b01,
      HALT_FINISH = 2'b10,
      HALT_NOW    = 2'b11
   } asq_halt_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_START = 3'b010,
      ST_WAIT  = 3'b100
   } asq_state_type;

   // conversions per sequence; the all-zero code means the full sixteen
   function automatic logic [POS_W:0] seq_len(input logic [POS_W-1:0] code);
      seq_len = (code == 4'h0) ? 5'h10 : {1'b0, code};
   endfunction

endpackage

// >>> hdl/asq_halt_ctrl.sv
// debug freeze synchroniser and halt decision
`timescale 1ns/10ps
module asq_halt_ctrl
   import asq_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // debug freeze pin
   input  wire logic       dbg_freeze_i,
   // control
   input  wire logic [1:0] halt_sel_i,
   input  wire logic       conv_active_i,
   // decisions
   output logic            frozen_o,
   output logic            start_ok_o,
   output logic            hold_o
);

   logic sync1_ff;
   logic sync2_ff;
   logic sync3_ff;
   logic frozen_ff;
   logic nxt_frozen;

   // a change is taken only once two later stages agree
   assign nxt_frozen = (sync2_ff == sync3_ff) ? sync2_ff : frozen_ff;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_ff  <= 1'b0;
         sync2_ff  <= 1'b0;
         sync3_ff  <= 1'b0;
         frozen_ff <= 1'b0;
      end else begin
         sync1_ff  <= dbg_freeze_i;
         sync2_ff  <= sync1_ff;
         sync3_ff  <= sync2_ff;
         frozen_ff <= nxt_frozen;
      end
   end

   wire logic sel_run  = (halt_sel_i == HALT_RUN) || (halt_sel_i == HALT_RSVD);
   wire logic sel_now  = (halt_sel_i == HALT_NOW);

   // finish mode lets the running conversion end but blocks the next one
   assign frozen_o   = frozen_ff;
   assign start_ok_o = !frozen_ff || sel_run;
   assign hold_o     = frozen_ff && sel_now && conv_active_i;

   chk_freeze_sync: assert property (@(posedge clk_i) disable iff (!resetn_i)
      dbg_freeze_i [*4] |=> frozen_o)
      else $error("freeze pin not seen after settling");
   chk_rsvd_runs: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (halt_sel_i == HALT_RSVD) |-> start_ok_o && !hold_o)
      else $error("reserved halt code did not act as run");

endmodule // asq_halt_ctrl

// >>> hdl/asq_seq_ctrl.sv
// converter sequence length, result queue and debug halt control
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
// Behaviour
// - control write aborts sequence, starts nothing
// - four-bit length, zero means sixteen
// - reset length is four conversions
// - fixed mode: Nth result to slot N
// - queue mode: position kept across scan-mode sequences
// - queue mode: position wraps past last slot
// - position counter readable in status
// - any control write clears position counter
// - freeze codes: run, reserved, finish, now
// - halt 1:0, queue 2, length 6:3
// - per-result complete flags kept current
module asq_seq_ctrl
   import asq_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   // register port
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wr_data_i,
   input  wire logic              wr_en_i,
   input  wire logic              rd_en_i,
   output logic      [DATA_W-1:0] rd_data_o,
   // debug
   input  wire logic              dbg_freeze_i,
   // converter core
   input  wire logic              conv_done_i,
   output logic                   conv_start_o,
   output logic                   conv_abort_o,
   output logic                   conv_hold_o,
   output logic                   result_wr_o,
   output logic      [POS_W-1:0]  result_idx_o,
   output logic                   busy_o,
   // interrupt
   output logic                   irq_o
);

   asq_state_type          state_ff;
   asq_state_type          nxt_state;
   logic [DATA_W-1:0]      ctrl_ff;
   logic [POS_W-1:0]       conv_cnt_ff;
   logic [POS_W-1:0]       nxt_conv_cnt;
   logic [POS_W-1:0]       pos_ff;
   logic [POS_W-1:0]       nxt_pos;
   logic [NUM_RESULTS-1:0] cmpl_ff;
   logic [NUM_RESULTS-1:0] nxt_cmpl;
   logic [IRQ_W-1:0]       irq_sts_ff;
   logic [IRQ_W-1:0]       nxt_irq_sts;
   logic [IRQ_W-1:0]       irq_mask_ff;
   logic                   scan_ff;
   logic                   seq_done_ff;
   logic                   conv_start_ff;
   logic                   conv_abort_ff;
   logic                   conv_hold_ff;
   logic                   result_wr_ff;
   logic [POS_W-1:0]       result_idx_ff;
   logic                   busy_ff;
   logic                   irq_ff;
   logic [DATA_W-1:0]      rd_data_ff;
   logic                   frozen_w;
   logic                   start_ok_w;
   logic                   hold_w;

   // address decode
   wire logic wr_ctrl     = wr_en_i && (addr_i == OFS_CTRL);
   wire logic wr_start    = wr_en_i && (addr_i == OFS_START);
   wire logic wr_other    = wr_en_i && (addr_i == OFS_OTHER_CTRL);
   wire logic wr_cmpl_lo  = wr_en_i && (addr_i == OFS_CMPL_LO);
   wire logic wr_cmpl_hi  = wr_en_i && (addr_i == OFS_CMPL_HI);
   wire logic wr_irq_sts  = wr_en_i && (addr_i == OFS_IRQ_STS);
   wire logic wr_irq_mask = wr_en_i && (addr_i == OFS_IRQ_MASK);
   // writes to the read-only status offset fall through and are dropped
   wire logic any_ctrl_wr = wr_ctrl || wr_start || wr_other;

   // control fields
   wire logic [POS_W-1:0] len_field = ctrl_ff[LEN_MSB:LEN_LSB];
   wire logic             queue_on  = ctrl_ff[QUEUE_BIT];
   wire logic [1:0]       halt_sel  = ctrl_ff[HALT_MSB:HALT_LSB];
   wire logic [POS_W:0]   len_w     = seq_len(len_field);

   // sequence progress
   wire logic busy_w    = (state_ff != ST_IDLE);
   // a done pulse that meets a control write is dropped: the write wins
   wire logic done_ok   = (state_ff == ST_WAIT) && conv_done_i && !any_ctrl_wr;
   wire logic last_conv = ({1'b0, conv_cnt_ff} == (len_w - 5'h01));
   wire logic seq_end   = done_ok && last_conv;
   wire logic abort_evt = any_ctrl_wr && busy_w;

   asq_halt_ctrl u_halt (
      .clk_i         (clk_i),
      .resetn_i      (resetn_i),
      .dbg_freeze_i  (dbg_freeze_i),
      .halt_sel_i    (halt_sel),
      .conv_active_i (state_ff == ST_WAIT),
      .frozen_o      (frozen_w),
      .start_ok_o    (start_ok_w),
      .hold_o        (hold_w)
   );

   // a write never starts a sequence except through the start register
   always_comb begin
      nxt_state = state_ff;
      if (any_ctrl_wr) begin
         nxt_state = wr_start ? ST_START : ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               nxt_state = ST_IDLE;
            end
            ST_START: begin
               if (start_ok_w) begin
                  nxt_state = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (done_ok) begin
                  nxt_state = (last_conv && !scan_ff) ? ST_IDLE : ST_START;
               end
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   // conversion and result position counters
   always_comb begin
      nxt_conv_cnt = conv_cnt_ff;
      nxt_pos      = pos_ff;
      if (any_ctrl_wr) begin
         nxt_conv_cnt = '0;
         nxt_pos      = '0;
      end else if (done_ok) begin
         nxt_conv_cnt = last_conv ? '0 : conv_cnt_ff + 4'h1;
         if (last_conv && !queue_on) begin
            nxt_pos = '0;
         end else begin
            // four-bit counter rolls from the last slot back to slot zero
            nxt_pos = pos_ff + 4'h1;
         end
      end
   end

   // complete flags: the start register clears them, a new result sets wins
   wire logic [NUM_RESULTS-1:0] cmpl_set = done_ok ? (16'h0001 << pos_ff) : '0;
   wire logic [NUM_RESULTS-1:0] cmpl_clr = wr_start   ? 16'hffff :
                                           wr_cmpl_lo ? {8'h00, wr_data_i} :
                                           wr_cmpl_hi ? {wr_data_i, 8'h00} : '0;
   assign nxt_cmpl = (cmpl_ff & ~cmpl_clr) | cmpl_set;

   // sticky interrupt sources, set beats write-one-clear
   wire logic [IRQ_W-1:0] irq_set = {abort_evt, seq_end};
   wire logic [IRQ_W-1:0] irq_clr = wr_irq_sts ? wr_data_i[IRQ_W-1:0] : '0;
   assign nxt_irq_sts = (irq_sts_ff & ~irq_clr) | irq_set;

   // read selection
   wire logic [DATA_W-1:0] status_w = {seq_done_ff, busy_w, frozen_w, 1'b0, pos_ff};
   wire logic [DATA_W-1:0] rd_mux =
      (addr_i == OFS_CTRL)     ? (ctrl_ff & CTRL_WR_MASK) :
      (addr_i == OFS_STATUS)   ? status_w :
      (addr_i == OFS_CMPL_LO)  ? cmpl_ff[7:0] :
      (addr_i == OFS_CMPL_HI)  ? cmpl_ff[15:8] :
      (addr_i == OFS_IRQ_STS)  ? {6'h00, irq_sts_ff} :
      (addr_i == OFS_IRQ_MASK) ? {6'h00, irq_mask_ff} :
      (addr_i == OFS_START)    ? {7'h00, scan_ff} : 8'h00;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_ff     <= CTRL_RESET;
         scan_ff     <= 1'b0;
         irq_mask_ff <= IRQ_MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wr_data_i & CTRL_WR_MASK;
         end
         if (wr_start) begin
            scan_ff <= wr_data_i[START_SCAN_BIT];
         end
         if (wr_irq_mask) begin
            irq_mask_ff <= wr_data_i[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff    <= ST_IDLE;
         conv_cnt_ff <= '0;
         pos_ff      <= '0;
         cmpl_ff     <= '0;
         irq_sts_ff  <= '0;
         seq_done_ff <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         conv_cnt_ff <= nxt_conv_cnt;
         pos_ff      <= nxt_pos;
         cmpl_ff     <= nxt_cmpl;
         irq_sts_ff  <= nxt_irq_sts;
         seq_done_ff <= seq_end || (seq_done_ff && !any_ctrl_wr);
      end
   end

   // output stage, all registered
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv_start_ff <= 1'b0;
         conv_abort_ff <= 1'b0;
         conv_hold_ff  <= 1'b0;
         result_wr_ff  <= 1'b0;
         result_idx_ff <= '0;
         busy_ff       <= 1'b0;
         irq_ff        <= 1'b0;
         rd_data_ff    <= '0;
      end else begin
         conv_start_ff <= (state_ff == ST_START) && start_ok_w && !any_ctrl_wr;
         conv_abort_ff <= abort_evt;
         conv_hold_ff  <= hold_w && !any_ctrl_wr;
         result_wr_ff  <= done_ok;
         if (done_ok) begin
            result_idx_ff <= pos_ff;
         end
         busy_ff    <= (nxt_state != ST_IDLE);
         // one cycle of lag keeps the interrupt pin free of decode glitches
         irq_ff     <= |(irq_sts_ff & irq_mask_ff);
         // data stand only in the cycle after the read strobe
         rd_data_ff <= rd_en_i ? rd_mux : 8'h00;
      end
   end

   assign rd_data_o    = rd_data_ff;
   assign conv_start_o = conv_start_ff;
   assign conv_abort_o = conv_abort_ff;
   assign conv_hold_o  = conv_hold_ff;
   assign result_wr_o  = result_wr_ff;
   assign result_idx_o = result_idx_ff;
   assign busy_o       = busy_ff;
   assign irq_o        = irq_ff;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   chk_abort_on_write: assert property (
      (wr_ctrl || wr_other) && busy_w |=> conv_abort_o && !busy_o ##1 !conv_start_o)
      else $error("control write did not abort the sequence");
   chk_len_decode: assert property (
      done_ok |-> (seq_end == ((len_field == 4'h0) ? (conv_cnt_ff == 4'hf) :
                               (conv_cnt_ff == len_field - 4'h1))))
      else $error("sequence ended at the wrong conversion count");
   chk_reset_len: assert property (
      $rose(resetn_i) |-> ctrl_ff == 8'h20 && len_w == 5'h04)
      else $error("reset length is not four");
   chk_fixed_slot: assert property (
      done_ok && !queue_on |=> result_wr_o && result_idx_o == $past(conv_cnt_ff))
      else $error("fixed mode result in wrong slot");
   chk_queue_keep: assert property (
      seq_end && queue_on && scan_ff |=> pos_ff == $past(pos_ff) + 4'h1)
      else $error("queue position reset at sequence end");
   chk_queue_wrap: assert property (
      done_ok && queue_on && pos_ff == 4'hf |=> pos_ff == 4'h0 ##1 result_idx_o == 4'hf)
      else $error("queue position did not wrap");
   chk_status_pos: assert property (
      rd_en_i && addr_i == OFS_STATUS |=> rd_data_o[3:0] == $past(pos_ff))
      else $error("status does not show result position");
   chk_pos_clear: assert property (
      any_ctrl_wr |=> pos_ff == 4'h0 && conv_cnt_ff == 4'h0)
      else $error("control write left position counter set");
   chk_halt_block: assert property (
      frozen_w && halt_sel[1] && state_ff == ST_START && !any_ctrl_wr
      |=> !conv_start_o && state_ff == ST_START)
      else $error("conversion started while halted");
   chk_halt_now: assert property (
      frozen_w && halt_sel == HALT_NOW && state_ff == ST_WAIT && !any_ctrl_wr |=> conv_hold_o)
      else $error("immediate halt did not hold conversion");
   chk_cmpl_flag: assert property (
      done_ok && !wr_en_i |=> cmpl_ff[$past(pos_ff)])
      else $error("complete flag not set for result");
   chk_rsvd_zero: assert property (
      rd_en_i && addr_i == OFS_CTRL |=> !rd_data_o[7])
      else $error("reserved control bit read as one");
   chk_start_gate: assert property (
      conv_start_o |-> $past(state_ff == ST_START) && busy_o)
      else $error("conversion started outside a sequence");
   chk_field_place: assert property (
      wr_ctrl |=> halt_sel == $past(wr_data_i[1:0]) && queue_on == $past(wr_data_i[2]) &&
                  len_field == $past(wr_data_i[6:3]))
      else $error("control fields not at their bit positions");
   chk_cmpl_clear: assert property (
      wr_start |=> cmpl_ff == 16'h0000)
      else $error("start write left complete flags set");

   cov_seq_end:  cover property (seq_end ##1 busy_o);
   cov_wrap:     cover property (done_ok && queue_on && pos_ff == 4'hf);
   cov_hold:     cover property (conv_hold_o [*3]);
   cov_abort:    cover property (abort_evt ##1 conv_abort_o);
   cov_len16:    cover property (seq_end && len_field == 4'h0);

endmodule // asq_seq_ctrl

// >>> verification/asq_seq_ctrl_bench.sv
// self-checking bench for the sequence, queue and halt control block
`timescale 1ns/10ps
module asq_seq_ctrl_bench;
   import asq_pkg::*;

   logic              clk_i;
   logic              resetn_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wr_data_i;
   logic              wr_en_i;
   logic              rd_en_i;
   logic [DATA_W-1:0] rd_data_o;
   logic              dbg_freeze_i;
   logic              conv_done_i;
   logic              conv_start_o;
   logic              conv_abort_o;
   logic              conv_hold_o;
   logic              result_wr_o;
   logic [POS_W-1:0]  result_idx_o;
   logic              busy_o;
   logic              irq_o;
   int                seed;
   int                fail_count;
   int                compares;
   int                lat;
   int                dly;
   int                n_start;
   int                n_abort;
   int                ns;
   int                na;
   bit                strict;
   logic [3:0]        exp_q[$];
   logic [7:0]        rdv;
   logic [3:0]        len_codes[4];

   asq_seq_ctrl dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
      .dbg_freeze_i(dbg_freeze_i), .conv_done_i(conv_done_i),
      .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
      .conv_hold_o(conv_hold_o), .result_wr_o(result_wr_o),
      .result_idx_o(result_idx_o), .busy_o(busy_o), .irq_o(irq_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_en_i   <= 1'b1;
      @(posedge clk_i);
      wr_en_i   <= 1'b0;
   endtask

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk_i);
      addr_i  <= a;
      rd_en_i <= 1'b1;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1 rdv = rd_data_o;
      chk(rdv & m, e);
   endtask

   task automatic drain;
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      chk(8'(exp_q.size()), 8'h00);
   endtask

   task automatic wait_start;
      int n;
      n = 0;
      ns = n_start;
      while (n_start == ns && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      chk(8'(n_start - ns), 8'h01);
   endtask

   // one fixed-mode sequence; freeze is random since codes 00 and 01 must ignore it
   task automatic seq(input logic [3:0] code, input bit do_wr);
      int          len;
      logic [15:0] m;
      logic [1:0]  h;
      len = (code == 4'h0) ? 16 : int'(code);
      h = 2'($unsigned($random(seed)) % 2);
      if (do_wr) wr(OFS_CTRL, {1'b0, code, 1'b0, h});
      dbg_freeze_i <= 1'($random(seed));
      for (int i = 0; i < len; i++) exp_q.push_back(4'(i));
      wr(OFS_START, 8'h00);
      drain();
      m = 16'((32'h1 << len) - 1);
      rchk(OFS_CMPL_LO, 8'hff, m[7:0]);
      rchk(OFS_CMPL_HI, 8'hff, m[15:8]);
      rchk(OFS_IRQ_STS, 8'h01, 8'h01);
      dbg_freeze_i <= 1'b0;
   endtask

   // converter stand-in: finishes each conversion after a delay, stalls while held
   always @(posedge clk_i) begin
      conv_done_i <= !conv_start_o && !conv_abort_o && !conv_hold_o && (dly == 1);
      if (conv_abort_o) n_abort++;
      if (conv_start_o) begin
         n_start++;
         dly <= (lat != 0) ? lat : 1 + int'($unsigned($random(seed)) % 4);
      end else if (conv_abort_o) begin
         dly <= 0;
      end else if (dly != 0 && !conv_hold_o) begin
         dly <= dly - 1;
      end
   end

   // result slots are checked against the model queue while it holds entries; extra results fail only when strict is set
   always @(posedge clk_i) begin
      if (result_wr_o === 1'b1) begin
         if (exp_q.size() != 0) chk({4'h0, result_idx_o}, {4'h0, exp_q.pop_front()});
         else if (strict) chk(8'hee, 8'h00);
      end
   end

   task end_of_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #300000;
      fail_count++;
      end_of_test();
   end

   initial begin
      seed = 36050;
      len_codes = '{4'h1, 4'h3, 4'hf, 4'h0};
      {addr_i, wr_data_i, wr_en_i, rd_en_i, dbg_freeze_i, conv_done_i} = '0;
      {fail_count, compares, lat, dly, n_start, n_abort} = '0;
      strict = 1'b1;
      resetn_i = 1'b0;
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      rchk(OFS_CTRL, 8'hff, 8'h20);
      seq(4'h4, 1'b0);
      wr(OFS_CTRL, 8'hff);
      rchk(OFS_CTRL, 8'hff, 8'h7f);
      $display("test reset and register done");
      foreach (len_codes[i]) seq(len_codes[i], 1'b1);
      chk({7'h0, irq_o}, 8'h00);
      wr(OFS_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk_i);
      #1 chk({7'h0, irq_o}, 8'h01);
      wr(OFS_IRQ_STS, 8'h01);
      repeat (2) @(posedge clk_i);
      #1 chk({7'h0, irq_o}, 8'h00);
      $display("test fixed lengths and interrupt done");
      // queue mode, scan, length 5, halt now; slow conversions leave room for the freeze
      strict = 1'b0;
      lat = 20;
      wr(OFS_CTRL, 8'h2f);
      for (int i = 0; i < 20; i++) exp_q.push_back(4'(i % 16));
      wr(OFS_START, 8'h01);
      drain();
      dbg_freeze_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      #1 chk({7'h0, conv_hold_o}, 8'h01);
      rchk(OFS_STATUS, 8'h0f, 8'h04);
      na = n_abort;
      ns = n_start;
      wr(OFS_CTRL, 8'h2f);
      repeat (20) @(posedge clk_i);
      chk(8'(n_abort - na), 8'h01);
      chk(8'(n_start - ns), 8'h00);
      chk({7'h0, busy_o}, 8'h00);
      rchk(OFS_STATUS, 8'h4f, 8'h00);
      dbg_freeze_i <= 1'b0;
      $display("test queue wrap and abort done");
      // fixed mode, length 2, finish then halt
      strict = 1'b1;
      wr(OFS_CTRL, 8'h12);
      wr(OFS_START, 8'h00);
      wait_start();
      dbg_freeze_i <= 1'b1;
      exp_q.push_back(4'h0);
      drain();
      ns = n_start;
      repeat (30) @(posedge clk_i);
      chk(8'(n_start - ns), 8'h00);
      chk({7'h0, conv_hold_o}, 8'h00);
      chk({7'h0, busy_o}, 8'h01);
      exp_q.push_back(4'h1);
      dbg_freeze_i <= 1'b0;
      drain();
      lat = 0;
      $display("test finish then halt done");
      end_of_test();
   end
endmodule // asq_seq_ctrl_bench
